// *** hdl/rir_top.sv ***
`timescale 1ns/1ps
module rir_top (
  input  wire logic                          clock_i,
  input  wire logic                          resetn_i,
  input  wire logic                          ext_reset_n_i,
  input  wire logic                          boot_mode_select_i,
  input  wire logic [rir_pkg::NUM_INT-1:0]   external_interrupt_inputs_i,
  input  wire logic                          int_edge_mode_i,
  input  wire logic [rir_pkg::NUM_INT-1:0]   int_clear_i,
  input  wire logic                          ack_req_i,
  input  wire logic [rir_pkg::WS_W-1:0]      ack_wait_i,
  input  wire rir_pkg::rir_core_s            core_bus_i,
  input  wire logic [rir_pkg::DATA_W-1:0]    data_in_i,
  input  wire logic [rir_pkg::NUM_AUX-1:0]   aux_out_i,
  input  wire logic [rir_pkg::NUM_AUX-1:0]   aux_oe_i,
  output logic                               phase_one_clock_o,
  output logic                               phase_three_clock_o,
  output rir_pkg::rir_bus_s                  bus_o,
  output logic [rir_pkg::DATA_W-1:0]         boot_vector_o,
  output logic                               running_o,
  output logic [rir_pkg::NUM_INT-1:0]        int_pending_o,
  output logic                               ack_busy_o,
  output logic [rir_pkg::NUM_AUX-1:0]        aux_out_o,
  output logic [rir_pkg::NUM_AUX-1:0]        aux_oe_o
);

  // ==========================================================================
  // pin synchronisers
  logic                        rst_pin_n;
  logic [rir_pkg::NUM_INT-1:0] int_pin;

  // reset pin may fall anywhere in the cycle; the sync absorbs alignment
  rir_sync #(
    .W    (1),
    .INIT (1'b0)
  ) u_rst_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .d_i      (ext_reset_n_i),
    .q_o      (rst_pin_n)
  );

  rir_sync #(
    .W    (rir_pkg::NUM_INT),
    .INIT (rir_pkg::INT_IDLE)
  ) u_int_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .d_i      (external_interrupt_inputs_i),
    .q_o      (int_pin)
  );

  // ==========================================================================
  // state
  rir_pkg::rir_st_s s;
  rir_pkg::rir_st_s next_s;

  logic                        h1_rise;
  logic                        h1_fall;
  logic                        h3_rise;
  logic                        h3_fall;
  logic [rir_pkg::NUM_INT-1:0] int_set;

  // phase one high while ph is set, phase three its complement
  assign h1_rise = ~s.ph;
  assign h3_fall = ~s.ph;
  assign h1_fall = s.ph;
  assign h3_rise = s.ph;

  always_comb begin
    next_s    = s;
    int_set   = rir_pkg::INT_NONE;
    next_s.ph = ~s.ph;
    next_s.aux_out = aux_out_i;

    // ========================================================================
    // interrupt sampling, taken as phase one falls
    if (h1_fall && rst_pin_n) begin
      if (int_edge_mode_i) begin
        // one low phase-one period is enough to catch the edge
        int_set = s.int_prev & ~int_pin;
      end else begin
        // a low held past one period can be seen again; the source must limit it
        int_set = ~int_pin;
      end
      next_s.int_prev = int_pin;
    end
    // a set arriving with its clear survives
    next_s.pend = (s.pend & ~int_clear_i) | int_set;

    if (ack_req_i) begin
      next_s.ack_req = 1'b1;
    end

    if (!rst_pin_n) begin
      // ======================================================================
      // reset held
      next_s.st       = rir_pkg::RIR_HELD;
      next_s.cnt      = rir_pkg::CNT_ZERO;
      next_s.ack_busy = 1'b0;
      next_s.ack_req  = 1'b0;
      next_s.pend     = rir_pkg::INT_NONE;
      next_s.int_prev = rir_pkg::INT_IDLE;
      if (h1_fall) begin
        next_s.bus.data_oe = 1'b0;
        next_s.bus.rw_oe   = 1'b0;
      end
      if (h3_fall) begin
        next_s.bus.addr_oe = 1'b0;
      end
      if (h3_rise) begin
        next_s.bus.memory_bank_strobes  = rir_pkg::STRB_IDLE;
        next_s.bus.peripheral_io_strobe = 1'b1;
      end
      if (h1_rise) begin
        next_s.bus.interrupt_ack_strobe = 1'b1;
      end
    end else begin
      unique case (s.st)
        rir_pkg::RIR_HELD: begin
          // strobes stay idle until a phase-one rise, so a fetch spans whole periods
          next_s.st           = rir_pkg::RIR_FETCH1;
          next_s.cnt          = rir_pkg::CNT_ZERO;
          next_s.bus.addr     = rir_pkg::RESET_VECTOR_ADDR;
          next_s.bus.addr_oe  = 1'b1;
          next_s.bus.rw       = 1'b1;
          next_s.bus.rw_oe    = 1'b1;
          next_s.bus.data_oe  = 1'b0;
          if (boot_mode_select_i) begin
            next_s.ws = rir_pkg::WS_MICROCOMP;
          end else begin
            next_s.ws = rir_pkg::WS_MICROPROC;
          end
        end
        rir_pkg::RIR_FETCH1,
        rir_pkg::RIR_FETCH2: begin
          if (h1_rise && next_s.bus.memory_bank_strobes == rir_pkg::STRB_IDLE) begin
            next_s.bus.memory_bank_strobes[rir_pkg::FETCH_STRB_BIT] = 1'b0;
          end
          if (h1_rise && !s.bus.memory_bank_strobes[rir_pkg::FETCH_STRB_BIT]) begin
            if (s.cnt == s.ws) begin
              // each fetch ends after its own wait states
              next_s.vector = data_in_i;
              next_s.cnt    = rir_pkg::CNT_ZERO;
              next_s.bus.memory_bank_strobes = rir_pkg::STRB_IDLE;
              if (s.st == rir_pkg::RIR_FETCH1) begin
                next_s.st = rir_pkg::RIR_FETCH2;
              end else begin
                next_s.st = rir_pkg::RIR_RUN;
              end
            end else begin
              next_s.cnt = s.cnt + rir_pkg::CNT_ONE;
            end
          end
        end
        rir_pkg::RIR_RUN: begin
          // ==================================================================
          // normal bus, launched on phase three
          if (h3_rise) begin
            next_s.bus.addr                 = core_bus_i.addr;
            next_s.bus.addr_oe              = 1'b1;
            next_s.bus.data                 = core_bus_i.data;
            next_s.bus.data_oe              = core_bus_i.data_oe;
            next_s.bus.rw                   = core_bus_i.rw;
            next_s.bus.rw_oe                = 1'b1;
            next_s.bus.memory_bank_strobes  = core_bus_i.memory_bank_strobes;
            next_s.bus.peripheral_io_strobe = core_bus_i.peripheral_io_strobe;
          end
          // ==================================================================
          // acknowledge cycle, stretched by its wait states
          if (h1_rise) begin
            if (s.ack_busy) begin
              if (s.ack_cnt == s.ack_ws) begin
                next_s.bus.interrupt_ack_strobe = 1'b1;
                next_s.ack_busy = 1'b0;
              end else begin
                next_s.ack_cnt = s.ack_cnt + rir_pkg::CNT_ONE;
              end
            end else if (s.ack_req || ack_req_i) begin
              next_s.bus.interrupt_ack_strobe = 1'b0;
              next_s.ack_busy = 1'b1;
              next_s.ack_req  = 1'b0;
              next_s.ack_cnt  = rir_pkg::CNT_ZERO;
              next_s.ack_ws   = ack_wait_i;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s <= rir_pkg::ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  assign phase_one_clock_o   = s.ph;
  assign phase_three_clock_o = ~s.ph;
  assign bus_o               = s.bus;
  assign boot_vector_o       = s.vector;
  assign running_o           = (s.st == rir_pkg::RIR_RUN);
  assign int_pending_o       = s.pend;
  assign ack_busy_o          = s.ack_busy;
  assign aux_out_o           = s.aux_out;
  // raw pin gates the enables directly so no clock edge is needed
  assign aux_oe_o            = aux_oe_i & {rir_pkg::NUM_AUX{ext_reset_n_i}};

endmodule

// *** hdl/rir_pkg.sv ***
// Summary of operation
// - the external reset pin is taken at any moment in a clock cycle, with no edge alignment.
// - a reset that misses the sampling window may cost exactly one extra clock before the sequence.
// - while reset is held the read/write direction output is released to high impedance.
// - with boot mode low the reset vector is fetched twice with seven wait states per fetch.
// - with boot mode high the reset vector is fetched twice with no wait states.
// - entering reset releases the data bus to high impedance on a phase-one edge.
// - entering reset releases the address bus to high impedance on a phase-three edge.
// - during reset the memory bank and peripheral strobes go high after a phase-three rise.
// - during reset the interrupt acknowledge strobe goes high after a phase-one rise.
// - reset forces flag, serial and timer pins to high impedance at once, with no clock.
// - the acknowledge strobe stays low for its whole bus cycle, stretched by each wait state.
package rir_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 32;
  localparam int NUM_INT = 4;
  localparam int NUM_AUX = 10;
  localparam int WS_W    = 3;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS     = 40;
  localparam int MIN_RESET_H1      = 10;
  localparam logic [WS_W-1:0] WS_MICROPROC = 3'h7;
  localparam logic [WS_W-1:0] WS_MICROCOMP = 3'h0;
  localparam logic [WS_W-1:0] CNT_ZERO     = 3'h0;
  localparam logic [WS_W-1:0] CNT_ONE      = 3'h1;

  // ==========================================================================
  // reset and fetch values
  localparam logic [ADDR_W-1:0] RESET_VECTOR_ADDR = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_ZERO         = 32'h00000000;
  localparam logic [1:0]        STRB_IDLE         = 2'h3;
  localparam logic [NUM_INT-1:0] INT_IDLE         = 4'hF;
  localparam logic [NUM_INT-1:0] INT_NONE         = 4'h0;
  localparam logic [NUM_AUX-1:0] AUX_ZERO         = 10'h000;
  localparam int FETCH_STRB_BIT = 0;

  // ==========================================================================
  // states, gray along reset -> fetch -> fetch -> run
  typedef enum logic [1:0] {
    RIR_HELD   = 2'h0,
    RIR_FETCH1 = 2'h1,
    RIR_FETCH2 = 2'h3,
    RIR_RUN    = 2'h2
  } rir_state_e;

  // ==========================================================================
  // pin groups
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              addr_oe;
    logic [DATA_W-1:0] data;
    logic              data_oe;
    logic              rw;
    logic              rw_oe;
    logic [1:0]        memory_bank_strobes;
    logic              peripheral_io_strobe;
    logic              interrupt_ack_strobe;
  } rir_bus_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              data_oe;
    logic              rw;
    logic [1:0]        memory_bank_strobes;
    logic              peripheral_io_strobe;
  } rir_core_s;

  typedef struct packed {
    logic                  ph;
    rir_state_e            st;
    logic [WS_W-1:0]       cnt;
    logic [WS_W-1:0]       ws;
    logic [DATA_W-1:0]     vector;
    rir_bus_s              bus;
    logic                  ack_req;
    logic                  ack_busy;
    logic [WS_W-1:0]       ack_cnt;
    logic [WS_W-1:0]       ack_ws;
    logic [NUM_INT-1:0]    pend;
    logic [NUM_INT-1:0]    int_prev;
    logic [NUM_AUX-1:0]    aux_out;
  } rir_st_s;

  localparam rir_bus_s BUS_RESET = '{
    addr: RESET_VECTOR_ADDR, addr_oe: 1'b0, data: DATA_ZERO, data_oe: 1'b0,
    rw: 1'b1, rw_oe: 1'b0, memory_bank_strobes: STRB_IDLE,
    peripheral_io_strobe: 1'b1, interrupt_ack_strobe: 1'b1};

  localparam rir_st_s ST_RESET = '{
    ph: 1'b0, st: RIR_HELD, cnt: CNT_ZERO, ws: CNT_ZERO, vector: DATA_ZERO,
    bus: BUS_RESET, ack_req: 1'b0, ack_busy: 1'b0, ack_cnt: CNT_ZERO,
    ack_ws: CNT_ZERO, pend: INT_NONE, int_prev: INT_IDLE, aux_out: AUX_ZERO};

endpackage

// *** hdl/rir_sync.sv ***
`timescale 1ns/1ps
module rir_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ==========================================================================
  // three stages, output follows once stages two and three agree
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } rir_sync_s;

  rir_sync_s s;
  rir_sync_s next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // disagreement holds the last value, costing at most one clock
    next_s.q  = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;

endmodule

// *** verification/rir_mem_model.sv ***
`timescale 1ns/1ps
// ==========================================
// boot memory: answers the two vector reads
module rir_mem_model #(
  parameter logic [31:0] VEC1 = 32'h0F1E2D3C,
  parameter logic [31:0] VEC2 = 32'hA5C3961E
) (
  input  wire logic              clock_i,
  input  wire logic              ext_reset_n_i,
  input  wire rir_pkg::rir_bus_s bus_i,
  output logic [31:0]            data_o
);
  logic        sel_q = 1'b0;
  logic        second = 1'b0;
  logic [31:0] junk = 32'h00000000;
  always_ff @(posedge clock_i) begin
    sel_q <= !bus_i.memory_bank_strobes[0];
    // unselected lines churn so a stale value is never captured
    junk  <= ~junk ^ 32'h5A5A5A5A;
    if (!ext_reset_n_i)
      second <= 1'b0;
    else if (sel_q && bus_i.memory_bank_strobes[0])
      second <= 1'b1;
  end
  assign data_o = !bus_i.memory_bank_strobes[0] ? (second ? VEC2 : VEC1) : junk;
endmodule

// *** verification/rir_checker_assertions.sv ***
`timescale 1ns/1ps
module rir_checker (
  input wire logic                        clock_i,
  input wire logic                        resetn_i,
  input wire logic                        ext_reset_n_i,
  input wire logic                        boot_mode_select_i,
  input wire logic                        phase_one_clock_o,
  input wire rir_pkg::rir_bus_s           bus_o,
  input wire logic                        running_o,
  input wire logic [rir_pkg::NUM_AUX-1:0] aux_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================
  // sequences
  sequence s_held;
    !ext_reset_n_i [*8];
  endsequence
  sequence s_fast_low;
    !bus_o.memory_bank_strobes[0] ##1 bus_o.memory_bank_strobes[0];
  endsequence
  // ==========================================
  // properties
  property p_aux_async;
    !ext_reset_n_i |-> aux_oe_o == '0;
  endproperty
  property p_rw_hiz;
    s_held |-> !bus_o.rw_oe;
  endproperty
  property p_data_hiz;
    s_held |-> !bus_o.data_oe;
  endproperty
  property p_addr_hiz;
    s_held |-> !bus_o.addr_oe;
  endproperty
  property p_strobe_idle;
    s_held |-> bus_o.memory_bank_strobes == 2'h3 && bus_o.peripheral_io_strobe;
  endproperty
  property p_ack_idle;
    s_held |-> bus_o.interrupt_ack_strobe;
  endproperty
  property p_ack_phase;
    $changed(bus_o.interrupt_ack_strobe) |-> phase_one_clock_o;
  endproperty
  property p_fetch_start;
    $rose(bus_o.addr_oe) |-> bus_o.rw_oe && !bus_o.data_oe
      && bus_o.memory_bank_strobes == 2'h3 && bus_o.interrupt_ack_strobe;
  endproperty
  property p_fetch_fast;
    $fell(bus_o.memory_bank_strobes[0]) && !running_o && boot_mode_select_i
      |-> ##1 s_fast_low;
  endproperty
  a_aux_async:   assert property (p_aux_async)   else $error("aux pins driven in reset");
  a_rw_hiz:      assert property (p_rw_hiz)      else $error("rw still driven");
  a_data_hiz:    assert property (p_data_hiz)    else $error("data still driven");
  a_addr_hiz:    assert property (p_addr_hiz)    else $error("addr still driven");
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobes not idle");
  a_ack_idle:    assert property (p_ack_idle)    else $error("ack not idle");
  a_ack_phase:   assert property (p_ack_phase)   else $error("ack edge off phase");
  a_fetch_start: assert property (p_fetch_start) else $error("bad fetch start");
  a_fetch_fast:  assert property (p_fetch_fast)  else $error("fast fetch length");
endmodule
bind rir_top rir_checker chk_u (.clock_i(clock_i), .resetn_i(resetn_i),
  .ext_reset_n_i(ext_reset_n_i), .boot_mode_select_i(boot_mode_select_i),
  .phase_one_clock_o(phase_one_clock_o), .bus_o(bus_o), .running_o(running_o),
  .aux_oe_o(aux_oe_o));

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] VEC1 = 32'h0F1E2D3C;
  localparam logic [31:0] VEC2 = 32'hA5C3961E;
  logic clock_i = 1'b0, resetn_i = 1'b0, ext_reset_n_i = 1'b0, boot_mode_select_i = 1'b1;
  logic ack_req_i = 1'b0, ph1, ph3, running_o, ack_busy_o;
  logic int_mode = 1'b1;
  logic [3:0] ints = 4'hF, clr = 4'h0, pend;
  logic [2:0] ack_wait = 3'h0;
  logic [31:0] data_in, vec;
  logic [9:0] aux_o, aux_oe_o;
  rir_pkg::rir_bus_s bus_o;
  int n_fail = 0, check_count = 0;
  rir_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .ext_reset_n_i(ext_reset_n_i),
    .boot_mode_select_i(boot_mode_select_i), .external_interrupt_inputs_i(ints),
    .int_edge_mode_i(int_mode), .int_clear_i(clr), .ack_req_i(ack_req_i), .ack_wait_i(ack_wait),
    .core_bus_i('1), .data_in_i(data_in), .aux_out_i(10'h2A5), .aux_oe_i(10'h3FF),
    .phase_one_clock_o(ph1), .phase_three_clock_o(ph3), .bus_o(bus_o), .boot_vector_o(vec),
    .running_o(running_o), .int_pending_o(pend), .ack_busy_o(ack_busy_o),
    .aux_out_o(aux_o), .aux_oe_o(aux_oe_o));
  rir_mem_model #(.VEC1(VEC1), .VEC2(VEC2)) mem_u (.clock_i(clock_i),
    .ext_reset_n_i(ext_reset_n_i), .bus_i(bus_o), .data_o(data_in));
  always #20 clock_i = ~clock_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // reset mid-cycle, then boot in one mode
  task automatic t_boot(input logic mode);
    int lows, fetches;
    logic prev;
    lows = 0;
    fetches = 0;
    prev = 1'b1;
    @(negedge clock_i);
    boot_mode_select_i = mode;
    #7 ext_reset_n_i = 1'b0; // not aligned to any edge
    #1 chk(aux_oe_o, 0, "aux enable");
    repeat (8) @(negedge clock_i);
    chk({bus_o.addr_oe, bus_o.data_oe, bus_o.rw_oe}, 0, "bus released");
    chk({bus_o.memory_bank_strobes, bus_o.peripheral_io_strobe}, 7, "strobes idle");
    chk(bus_o.interrupt_ack_strobe, 1, "ack idle");
    repeat (16) @(negedge clock_i);
    ext_reset_n_i = 1'b1; // held twelve phase-one periods
    for (int i = 0; i < 300 && !running_o; i++) begin
      @(negedge clock_i);
      if (!bus_o.memory_bank_strobes[0]) begin
        lows++;
        chk({bus_o.addr_oe, bus_o.rw_oe, bus_o.rw, bus_o.data_oe}, 4'hE, "fetch bus");
        chk(bus_o.addr, rir_pkg::RESET_VECTOR_ADDR, "fetch address");
      end
      if (prev && !bus_o.memory_bank_strobes[0]) begin
        fetches++;
        if (fetches == 2)
          chk(vec, VEC1, "first vector");
      end
      prev = bus_o.memory_bank_strobes[0];
    end
    chk(running_o, 1, "boot finished");
    chk(fetches, 2, "fetch count");
    chk(lows, mode ? 4 : 32, "fetch wait states");
    chk(vec, VEC2, "boot vector");
    chk(aux_oe_o, 10'h3FF, "aux enabled");
    chk(aux_o, 10'h2A5, "aux passthrough");
    repeat (2) @(negedge clock_i);
    chk({bus_o.addr_oe, bus_o.rw_oe}, 2'h3, "buses enabled");
    chk(bus_o.addr, 24'hFFFFFF, "run address");
  endtask
  // ==========================================
  // acknowledge cycle stretched by wait states
  task automatic t_ack(input logic [2:0] w);
    int lows, i;
    logic p;
    lows = 0;
    @(negedge clock_i);
    p = ph1;
    chk(ph3, !p, "phase three");
    ack_wait = w;
    ack_req_i = 1'b1;
    @(negedge clock_i);
    chk(ph1, !p, "phase one toggle");
    ack_req_i = 1'b0;
    for (i = 0; i < 8 && bus_o.interrupt_ack_strobe; i++)
      @(negedge clock_i);
    chk(ack_busy_o, 1, "ack busy");
    for (i = 0; i < 40 && !bus_o.interrupt_ack_strobe; i++) begin
      lows++;
      @(negedge clock_i);
    end
    chk(lows, (int'(w) + 1) * 2, "ack low length");
    chk(ack_busy_o, 0, "ack done");
    repeat (4) @(negedge clock_i);
  endtask
  // ==========================================
  // edge or level interrupt held two phase-one periods
  task automatic t_int(input logic lvl);
    @(negedge clock_i);
    int_mode = !lvl;
    ints = 4'hB; // within one to two periods
    repeat (4) @(negedge clock_i);
    ints = 4'hF;
    repeat (6) @(negedge clock_i);
    chk(pend, 4'h4, "pending set");
    clr = 4'hF;
    @(negedge clock_i);
    clr = 4'h0;
    @(negedge clock_i);
    chk(pend, 4'h0, "pending cleared");
  endtask
  initial begin
    repeat (8) @(negedge clock_i);
    resetn_i = 1'b1;
    t_boot(1'b1);
    t_int(1'b0);
    t_int(1'b1);
    t_ack(3'h0);
    t_ack(3'h3);
    t_ack(3'h7);
    // reset again from run, slow boot
    t_boot(1'b0);
    t_ack(3'h1);
    end_sim();
  end
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule
